// >>> src/ift_core.sv
// result registers of the inductive detectors and the temperature computation
// assumes a sensing engine on ref_clk that pulses cycle_done with stable results
// and a serial protocol engine that turns bus frames into register strobes
//
// What this block does
// - metal on inductive channels zero-two sets bit0
// - enabled band processing detecting metal sets bit3
// - band flags: near bit5, touch bit6
// - band flags bit7 is count-above-average sign
// - band magnitude 16 bits, low byte first
// - temperature change triggers reseed of other channels
// - temperature equals a times two^19 over b-count plus c
// - temperature input is channel three only
// - multiplier register plus one, range 1-256
// - divider register plus one, range 1-256
// - offset register, zero to 255, added
// - legacy layout packs two nibbles, offset follows
// - factory parts load a, b, c, fine from storage
// - firmware two runs without magnetic channels
// - channel three gain select register exists
// - temperature trip sets global event bit4
// - temperature trip sets temperature flags bit7
// - temperature result 16 bits, low byte first
`timescale 1ns/1ps
`include "ift_regs.svh"

module ift_core #(
    parameter int FW_VERSION    = 2,
    parameter bit LEGACY_LAYOUT = 1'b0
) (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rvalid,
    input  wire logic        cycle_done,
    input  wire logic [2:0]  ch_inductive_cfg,
    input  wire logic [2:0]  ch_metal_det,
    input  wire logic        band_enable,
    input  wire logic        band_detect,
    input  wire logic        band_near,
    input  wire logic        band_touch,
    input  wire logic        band_above_avg,
    input  wire logic [15:0] band_magnitude,
    input  wire logic [15:0] temperature_channel_count,
    input  wire logic        magnetic_ch_en,
    input  wire logic        otp_load,
    input  wire logic [7:0]  otp_mul,
    input  wire logic [7:0]  otp_div,
    input  wire logic [7:0]  otp_ofs,
    input  wire logic [3:0]  otp_fine,
    output logic             reseed_req,
    output logic [7:0]       temp_gain_select
);

    initial begin
        if (FW_VERSION < 0 || FW_VERSION > 2) begin
            $error("FW_VERSION must be 0, 1 or 2");
        end
    end

    // ------------------------------------------------------------------
    // register write decode and writable registers
    // ------------------------------------------------------------------
    wire sel_set = reg_wr && (reg_addr == `IFT_OFS_TEMP_SETTINGS);
    wire sel_gain = reg_wr && (reg_addr == `IFT_OFS_TEMP_GAIN_SEL);
    wire sel_mul = reg_wr && (reg_addr == `IFT_OFS_TEMP_CAL_MUL);
    wire sel_div = reg_wr && (reg_addr == `IFT_OFS_TEMP_CAL_DIV);
    wire sel_ofs = reg_wr && (reg_addr == `IFT_OFS_TEMP_CAL_OFS) && !LEGACY_LAYOUT;

    ift_pkg::ift_byte_t settings_r;
    ift_pkg::ift_byte_t gain_r;
    ift_pkg::ift_byte_t mul_r;
    ift_pkg::ift_byte_t div_r;
    ift_pkg::ift_byte_t ofs_r;

    // storage load takes precedence over a master write in the same cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            settings_r <= `IFT_RST_TEMP_SETTINGS;
            gain_r     <= `IFT_RST_TEMP_GAIN_SEL;
            mul_r      <= `IFT_RST_TEMP_CAL_MUL;
            div_r      <= `IFT_RST_TEMP_CAL_DIV;
            ofs_r      <= `IFT_RST_TEMP_CAL_OFS;
        end else if (otp_load) begin
            gain_r <= {4'h0, otp_fine};
            mul_r  <= LEGACY_LAYOUT ? {otp_mul[3:0], otp_div[3:0]} : otp_mul;
            div_r  <= LEGACY_LAYOUT ? otp_ofs : otp_div;
            ofs_r  <= otp_ofs;
        end else begin
            if (sel_set) settings_r <= reg_wdata;
            if (sel_gain) gain_r <= reg_wdata;
            if (sel_mul) mul_r <= reg_wdata;
            if (sel_div) div_r <= reg_wdata;
            if (sel_ofs) ofs_r <= reg_wdata;
        end
    end

    assign temp_gain_select = gain_r;

    // ------------------------------------------------------------------
    // calibration constants in effect
    // ------------------------------------------------------------------
    // legacy: nibbles at the first register, offset at the next one
    wire [8:0] eff_mul = LEGACY_LAYOUT ? {5'h00, mul_r[7:4]} + 9'h001
                                       : {1'b0, mul_r} + 9'h001;
    wire [8:0] eff_div = LEGACY_LAYOUT ? {5'h00, mul_r[3:0]} + 9'h001
                                       : {1'b0, div_r} + 9'h001;
    wire [7:0] eff_ofs = LEGACY_LAYOUT ? div_r : ofs_r;

    // ------------------------------------------------------------------
    // inductive results, captured at the end of each sensing cycle
    // ------------------------------------------------------------------
    wire       metal_detect_event = |(ch_metal_det & ch_inductive_cfg);
    wire       band_processing_event = band_enable && band_detect;
    wire [7:0] band_flags_nxt = {band_above_avg, band_touch, band_near, 5'h00};

    logic       ev_metal_r;
    logic       ev_band_r;
    logic       ev_temp_r;
    logic [7:0] band_flags_r;
    logic [15:0] band_out_r;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ev_metal_r   <= 1'b0;
            ev_band_r    <= 1'b0;
            band_flags_r <= `IFT_RST_BYTE;
            band_out_r   <= `IFT_RST_WORD;
        end else if (cycle_done) begin
            ev_metal_r   <= metal_detect_event;
            ev_band_r    <= band_processing_event;
            band_flags_r <= band_flags_nxt;
            band_out_r   <= band_magnitude;
        end
    end

    // ------------------------------------------------------------------
    // temperature divider: (a << 19) / (b * count), restoring, one bit a cycle
    // ------------------------------------------------------------------
    // old firmware only runs with the magnetic channels active
    wire temp_run_ok = (FW_VERSION >= 2) || magnetic_ch_en;
    wire [24:0] den_nxt = 25'(eff_div * temperature_channel_count);
    wire start = cycle_done && temp_run_ok && (temperature_channel_count != 16'h0000);

    ift_pkg::ift_state_e state_r;
    logic [27:0] quo_r;
    logic [25:0] rem_r;
    logic [24:0] den_r;
    logic [4:0]  step_r;
    logic [7:0]  ofs_cap_r;

    wire [25:0] rem_sh = {rem_r[24:0], quo_r[27]};
    wire        fits   = rem_sh >= {1'b0, den_r};
    wire [25:0] rem_nxt = fits ? rem_sh - {1'b0, den_r} : rem_sh;
    wire [27:0] quo_nxt = {quo_r[26:0], fits};
    wire        div_last = (state_r == ift_pkg::IFT_DIV) && (step_r == 5'd1);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_r   <= ift_pkg::IFT_IDLE;
            quo_r     <= 28'h000_0000;
            rem_r     <= 26'h000_0000;
            den_r     <= 25'h000_0000;
            step_r    <= 5'd0;
            ofs_cap_r <= `IFT_RST_BYTE;
        end else begin
            unique case (state_r)
                ift_pkg::IFT_IDLE: begin
                    if (start) begin
                        quo_r     <= {eff_mul, 19'h0_0000};
                        rem_r     <= 26'h000_0000;
                        den_r     <= den_nxt;
                        step_r    <= `IFT_DIV_STEPS;
                        ofs_cap_r <= eff_ofs;
                        state_r   <= ift_pkg::IFT_DIV;
                    end
                end
                ift_pkg::IFT_DIV: begin
                    quo_r  <= quo_nxt;
                    rem_r  <= rem_nxt;
                    step_r <= step_r - 5'd1;
                    if (step_r == 5'd1) begin
                        state_r <= ift_pkg::IFT_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // temperature result, trip and reseed
    // ------------------------------------------------------------------
    wire [28:0] temp_sum = {1'b0, quo_nxt} + {21'h00_0000, ofs_cap_r};
    wire [15:0] temp_sat = (temp_sum[28:16] != 13'h0000) ? 16'hffff
                                                         : temp_sum[15:0];
    logic [15:0] temp_out_r;
    logic        have_temp_r;
    wire  [15:0] temp_delta = (temp_sat > temp_out_r) ? temp_sat - temp_out_r
                                                      : temp_out_r - temp_sat;
    wire  [15:0] thresh = {12'h000, settings_r[`IFT_TS_THRESH_MSB:0]};
    wire         trip_nxt = have_temp_r && (temp_delta > thresh);
    logic        trip_r;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            temp_out_r  <= `IFT_RST_WORD;
            have_temp_r <= 1'b0;
            trip_r      <= 1'b0;
            ev_temp_r   <= 1'b0;
            reseed_req  <= 1'b0;
        end else begin
            reseed_req <= 1'b0;
            if (div_last) begin
                temp_out_r  <= temp_sat;
                have_temp_r <= 1'b1;
                trip_r      <= trip_nxt;
                ev_temp_r   <= trip_nxt;
                reseed_req  <= trip_nxt && settings_r[`IFT_TS_RESEED_EN_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // register read port, one cycle after the read strobe
    // ------------------------------------------------------------------
    wire [7:0] global_event = {3'h0, ev_temp_r, ev_band_r, 2'h0, ev_metal_r};
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        unique case (reg_addr)
            `IFT_OFS_GLOBAL_EVENT:  rd_mux = global_event;
            `IFT_OFS_BAND_FLAGS:    rd_mux = band_flags_r;
            `IFT_OFS_BAND_OUT_LO:   rd_mux = band_out_r[7:0];
            `IFT_OFS_BAND_OUT_HI:   rd_mux = band_out_r[15:8];
            `IFT_OFS_TEMP_FLAGS:    rd_mux = {trip_r, 7'h00};
            `IFT_OFS_TEMP_OUT_LO:   rd_mux = temp_out_r[7:0];
            `IFT_OFS_TEMP_OUT_HI:   rd_mux = temp_out_r[15:8];
            `IFT_OFS_TEMP_SETTINGS: rd_mux = settings_r;
            `IFT_OFS_TEMP_GAIN_SEL: rd_mux = gain_r;
            `IFT_OFS_TEMP_CAL_MUL:  rd_mux = mul_r;
            `IFT_OFS_TEMP_CAL_DIV:  rd_mux = div_r;
            `IFT_OFS_TEMP_CAL_OFS:  rd_mux = LEGACY_LAYOUT ? 8'h00 : ofs_r;
            default:                rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata  <= `IFT_RST_BYTE;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) reg_rdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_div_begin;
        state_r == ift_pkg::IFT_IDLE && start;
    endsequence
    sequence s_div_end;
        div_last;
    endsequence

    AST_METAL_EVENT: assert property (
        cycle_done |=> ev_metal_r == $past(|(ch_metal_det & ch_inductive_cfg)))
        else $error("metal event bit does not follow inductive detection");
    AST_BAND_EVENT: assert property (
        cycle_done && !band_enable |=> !ev_band_r)
        else $error("band event set while band processing disabled");
    AST_BAND_FLAGS: assert property (
        cycle_done |=> band_flags_r[`IFT_BF_NEAR_BIT] == $past(band_near)
                       && band_flags_r[`IFT_BF_TOUCH_BIT] == $past(band_touch))
        else $error("near or touch flag wrong");
    AST_BAND_SIGN: assert property (
        cycle_done |=> band_flags_r[`IFT_BF_SIGN_BIT] == $past(band_above_avg))
        else $error("sign flag wrong");
    AST_BAND_HI_READ: assert property (
        reg_rd && reg_addr == `IFT_OFS_BAND_OUT_HI && !cycle_done
        |=> reg_rvalid && reg_rdata == band_out_r[15:8])
        else $error("band high byte read wrong");
    AST_DIV_LENGTH: assert property (
        s_div_begin |=> (state_r == ift_pkg::IFT_DIV && step_r == `IFT_DIV_STEPS) ##27 s_div_end)
        else $error("division does not take 28 cycles");
    AST_ZERO_COUNT: assert property (
        state_r == ift_pkg::IFT_IDLE && temperature_channel_count == 16'h0000
        |=> state_r == ift_pkg::IFT_IDLE && $stable(temp_out_r))
        else $error("zero count disturbed the temperature result");
    AST_OLD_FW_HOLD: assert property (
        FW_VERSION < 2 && !magnetic_ch_en && state_r == ift_pkg::IFT_IDLE
        |=> state_r == ift_pkg::IFT_IDLE)
        else $error("temperature ran without magnetic channels on old firmware");
    AST_TRIP_EVENT: assert property (
        ev_temp_r == trip_r)
        else $error("temperature event and trip flag disagree");
    AST_RESEED: assert property (
        reseed_req |-> trip_r && settings_r[`IFT_TS_RESEED_EN_BIT] && $past(div_last))
        else $error("reseed without enabled trip");
    AST_RO_WRITE: assert property (
        reg_wr && !cycle_done && !div_last |=> $stable(band_out_r) && $stable(temp_out_r))
        else $error("write changed a read-only result");
    AST_GAIN_WRITE: assert property (
        reg_wr && reg_addr == `IFT_OFS_TEMP_GAIN_SEL && !otp_load
        |=> temp_gain_select == $past(reg_wdata))
        else $error("gain select write lost");
    AST_GAIN_LOAD: assert property (
        otp_load |=> temp_gain_select == {4'h0, $past(otp_fine)})
        else $error("gain select not loaded from storage");
    AST_MUL_WRITE: assert property (
        reg_wr && reg_addr == `IFT_OFS_TEMP_CAL_MUL && !otp_load
        |=> mul_r == $past(reg_wdata))
        else $error("multiplier write lost");
    AST_DIV_WRITE: assert property (
        reg_wr && reg_addr == `IFT_OFS_TEMP_CAL_DIV && !otp_load
        |=> div_r == $past(reg_wdata))
        else $error("divider write lost");
    AST_OFS_WRITE: assert property (
        !LEGACY_LAYOUT && reg_wr && reg_addr == `IFT_OFS_TEMP_CAL_OFS && !otp_load
        |=> ofs_r == $past(reg_wdata))
        else $error("offset write lost");
    AST_LEGACY_OFS: assert property (
        LEGACY_LAYOUT && reg_rd && reg_addr == `IFT_OFS_TEMP_CAL_OFS
        |=> reg_rdata == 8'h00)
        else $error("legacy layout exposes a fifth calibration register");
    AST_TEMP_HOLD: assert property (
        !div_last |=> $stable(temp_out_r) && $stable(trip_r))
        else $error("temperature result changed outside a division end");
    AST_TEMP_HI_READ: assert property (
        reg_rd && reg_addr == `IFT_OFS_TEMP_OUT_HI && !div_last
        |=> reg_rvalid && reg_rdata == temp_out_r[15:8])
        else $error("temperature high byte read wrong");
    AST_TEMP_FLAG_READ: assert property (
        reg_rd && reg_addr == `IFT_OFS_TEMP_FLAGS && !div_last
        |=> reg_rdata == {trip_r, 7'h00})
        else $error("temperature flags read wrong");

endmodule

// >>> src/ift_regs.svh
// register offsets, field positions and timing counts of the inductive flag
// and temperature block; assumes an 8-bit register port with byte addresses
`ifndef IFT_REGS_SVH
`define IFT_REGS_SVH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define IFT_OFS_GLOBAL_EVENT   8'h11
`define IFT_OFS_BAND_FLAGS     8'h13
`define IFT_OFS_BAND_OUT_LO    8'h14
`define IFT_OFS_BAND_OUT_HI    8'h15
`define IFT_OFS_TEMP_FLAGS     8'h19
`define IFT_OFS_TEMP_OUT_LO    8'h1a
`define IFT_OFS_TEMP_OUT_HI    8'h1b
`define IFT_OFS_TEMP_SETTINGS  8'hc0
`define IFT_OFS_TEMP_GAIN_SEL  8'hc1
`define IFT_OFS_TEMP_CAL_MUL   8'hc2
`define IFT_OFS_TEMP_CAL_DIV   8'hc3
`define IFT_OFS_TEMP_CAL_OFS   8'hc4

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define IFT_EV_METAL_BIT       0
`define IFT_EV_BAND_BIT        3
`define IFT_EV_TEMP_BIT        4
`define IFT_BF_NEAR_BIT        5
`define IFT_BF_TOUCH_BIT       6
`define IFT_BF_SIGN_BIT        7
`define IFT_TF_TRIP_BIT        7
`define IFT_TS_RESEED_EN_BIT   7
`define IFT_TS_THRESH_MSB      3
`define IFT_NUM_SHIFT          19

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define IFT_RST_TEMP_SETTINGS  8'h80
`define IFT_RST_TEMP_GAIN_SEL  8'h00
`define IFT_RST_TEMP_CAL_MUL   8'h00
`define IFT_RST_TEMP_CAL_DIV   8'h00
`define IFT_RST_TEMP_CAL_OFS   8'h00
`define IFT_RST_BYTE           8'h00
`define IFT_RST_WORD           16'h0000

// ------------------------------------------------------------------
// timing counts
// ------------------------------------------------------------------
`define IFT_DIV_STEPS          5'd28

`endif

// >>> src/ift_pkg.sv
// types shared by the inductive flag and temperature block
// assumes nothing of its surroundings
package ift_pkg;

    typedef enum logic [0:0] {
        IFT_IDLE = 1'b0,
        IFT_DIV  = 1'b1
    } ift_state_e;

    typedef logic [7:0] ift_byte_t;

endpackage

// >>> tb/ift_sense_model.sv
// sensing engine model: pulses cycle_done with one cycle of results
// assumes the testbench calls its tasks; all changes land on ref_clk rises
`timescale 1ns/1ps

module ift_sense_model (
    input  wire logic        ref_clk,
    output logic             cycle_done,
    output logic [2:0]       ch_inductive_cfg,
    output logic [2:0]       ch_metal_det,
    output logic [4:0]       band_bits,
    output logic [15:0]      band_magnitude,
    output logic [15:0]      temperature_channel_count,
    output logic             otp_load,
    output logic [7:0]       otp_mul,
    output logic [7:0]       otp_div,
    output logic [7:0]       otp_ofs,
    output logic [3:0]       otp_fine
);
    initial begin
        {cycle_done, ch_inductive_cfg, ch_metal_det, band_bits} = '0;
        {band_magnitude, temperature_channel_count} = '0;
        {otp_load, otp_mul, otp_div, otp_ofs, otp_fine} = '0;
    end

    // results only hold with the strobe; afterwards they are scrambled
    task automatic run(input logic [2:0] cfg, input logic [2:0] det,
                       input logic [4:0] band, input logic [15:0] mag,
                       input logic [15:0] cnt);
        @(posedge ref_clk);
        cycle_done <= 1'b1;
        ch_inductive_cfg <= cfg;
        ch_metal_det <= det;
        band_bits <= band;
        band_magnitude <= mag;
        temperature_channel_count <= cnt;
        @(posedge ref_clk);
        cycle_done <= 1'b0;
        ch_inductive_cfg <= ~cfg;
        ch_metal_det <= ~det;
        band_bits <= ~band;
        band_magnitude <= ~mag;
        temperature_channel_count <= ~cnt;
    endtask

    task automatic load(input logic [7:0] m, input logic [7:0] d,
                        input logic [7:0] o, input logic [3:0] f);
        @(posedge ref_clk);
        otp_load <= 1'b1;
        {otp_mul, otp_div, otp_ofs, otp_fine} <= {m, d, o, f};
        @(posedge ref_clk);
        otp_load <= 1'b0;
        {otp_mul, otp_div, otp_ofs, otp_fine} <= ~{m, d, o, f};
    endtask
endmodule

// >>> tb/inductive_flags_and_temp_ui_tb.sv
// self-checking bench of ift_core through its register port
// assumes ift_regs.svh offsets; sensing results come from ift_sense_model
`timescale 1ns/1ps
`include "ift_regs.svh"
`define TB_CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end

module inductive_flags_and_temp_ui_tb;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_rd = 1'b0;
    logic        magnetic_ch_en = 1'b0;
    logic [7:0]  reg_rdata;
    logic        reg_rvalid;
    logic        reseed_req;
    logic [7:0]  temp_gain_select;
    logic [7:0]  old_rdata;
    logic        cycle_done;
    logic        otp_load;
    logic [2:0]  cfg;
    logic [2:0]  det;
    logic [4:0]  band;
    logic [15:0] mag;
    logic [15:0] cnt;
    logic [7:0]  om;
    logic [7:0]  od;
    logic [7:0]  oo;
    logic [3:0]  of;
    int          n_fail = 0;
    int          checks = 0;
    int          n_reseed = 0;

    always #2.5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) if (reseed_req === 1'b1) n_reseed++;

    ift_sense_model sense (.ref_clk(ref_clk), .cycle_done(cycle_done),
        .ch_inductive_cfg(cfg), .ch_metal_det(det), .band_bits(band),
        .band_magnitude(mag), .temperature_channel_count(cnt), .otp_load(otp_load),
        .otp_mul(om), .otp_div(od), .otp_ofs(oo), .otp_fine(of));

    ift_core uut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .cycle_done(cycle_done), .ch_inductive_cfg(cfg),
        .ch_metal_det(det), .band_enable(band[4]), .band_detect(band[3]),
        .band_near(band[2]), .band_touch(band[1]), .band_above_avg(band[0]),
        .band_magnitude(mag), .temperature_channel_count(cnt),
        .magnetic_ch_en(magnetic_ch_en), .otp_load(otp_load), .otp_mul(om),
        .otp_div(od), .otp_ofs(oo), .otp_fine(of), .reseed_req(reseed_req),
        .temp_gain_select(temp_gain_select));

    // old firmware, legacy layout: runs only with the magnetic channels on
    ift_core #(.FW_VERSION(1), .LEGACY_LAYOUT(1'b1)) uut_fw1 (.ref_clk(ref_clk),
        .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(old_rdata), .reg_rvalid(), .cycle_done(cycle_done),
        .ch_inductive_cfg(cfg), .ch_metal_det(det), .band_enable(band[4]),
        .band_detect(band[3]), .band_near(band[2]), .band_touch(band[1]),
        .band_above_avg(band[0]), .band_magnitude(mag), .temperature_channel_count(cnt),
        .magnetic_ch_en(magnetic_ch_en), .otp_load(otp_load), .otp_mul(om), .otp_div(od),
        .otp_ofs(oo), .otp_fine(of), .reseed_req(), .temp_gain_select());

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic final_report();
        if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge ref_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~d};
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        int i;
        i = 0;
        @(posedge ref_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge ref_clk);
        {reg_rd, reg_addr} <= {1'b0, ~a};
        @(negedge ref_clk);
        while (reg_rvalid !== 1'b1 && i < 4) begin
            @(negedge ref_clk);
            i++;
        end
        if (reg_rvalid !== 1'b1) begin
            n_fail++;
            final_report();
        end else
            `TB_CHK(reg_rdata, e)
    endtask

    // (a+1)*2^19 / ((b+1)*n) + c, truncated and saturated
    function automatic logic [15:0] t_exp(input logic [7:0] a, input logic [7:0] b,
                                          input logic [7:0] c, input logic [15:0] n);
        logic [39:0] q;
        q = ((40'(a) + 40'h0000_0001) << 19) / ((40'(b) + 40'h0000_0001) * 40'(n));
        q = q + 40'(c);
        return (q > 40'h0000_ffff) ? 16'hffff : q[15:0];
    endfunction

    task automatic temp_run(input logic [15:0] n, input logic [15:0] e,
                            input logic [7:0] trip, input int seeds);
        sense.run(3'b000, 3'b000, 5'b00000, 16'h0000, n);
        repeat (32) @(posedge ref_clk);
        rd(`IFT_OFS_TEMP_OUT_LO, e[7:0]);
        rd(`IFT_OFS_TEMP_OUT_HI, e[15:8]);
        rd(`IFT_OFS_TEMP_FLAGS, trip);
        rd(`IFT_OFS_GLOBAL_EVENT, trip >> 3);
        `TB_CHK(n_reseed, seeds)
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    logic [2:0]  c_cfg [3] = '{3'b001, 3'b110, 3'b100};
    logic [2:0]  c_det [3] = '{3'b011, 3'b001, 3'b100};
    logic [4:0]  c_bnd [3] = '{5'b11101, 5'b10010, 5'b01000};
    logic [15:0] c_mag [3] = '{16'h1234, 16'hbeef, 16'h00ff};
    logic [7:0]  c_ev  [3] = '{8'h09, 8'h00, 8'h01};
    logic [7:0]  c_fl  [3] = '{8'ha0, 8'h40, 8'h00};

    initial begin
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        rd(`IFT_OFS_TEMP_SETTINGS, `IFT_RST_TEMP_SETTINGS);
        rd(`IFT_OFS_TEMP_GAIN_SEL, 8'h00);
        rd(`IFT_OFS_TEMP_CAL_MUL, 8'h00);
        rd(`IFT_OFS_TEMP_CAL_DIV, 8'h00);
        rd(`IFT_OFS_TEMP_CAL_OFS, 8'h00);
        rd(8'h20, 8'h00);
        `TB_CHK(temp_gain_select, 8'h00)
        wr(`IFT_OFS_GLOBAL_EVENT, 8'hff);
        wr(`IFT_OFS_BAND_FLAGS, 8'hff);
        wr(`IFT_OFS_BAND_OUT_LO, 8'hff);
        wr(`IFT_OFS_TEMP_OUT_HI, 8'hff);
        rd(`IFT_OFS_GLOBAL_EVENT, 8'h00);
        rd(`IFT_OFS_BAND_FLAGS, 8'h00);
        rd(`IFT_OFS_BAND_OUT_LO, 8'h00);
        rd(`IFT_OFS_TEMP_OUT_HI, 8'h00);
        wr(`IFT_OFS_TEMP_GAIN_SEL, 8'h5a);
        rd(`IFT_OFS_TEMP_GAIN_SEL, 8'h5a);
        `TB_CHK(temp_gain_select, 8'h5a)
        for (int k = 0; k < 3; k++) begin
            sense.run(c_cfg[k], c_det[k], c_bnd[k], c_mag[k], 16'h0000);
            rd(`IFT_OFS_GLOBAL_EVENT, c_ev[k]);
            rd(`IFT_OFS_BAND_FLAGS, c_fl[k]);
            rd(`IFT_OFS_BAND_OUT_LO, c_mag[k][7:0]);
            rd(`IFT_OFS_BAND_OUT_HI, c_mag[k][15:8]);
        end
        // magnetic channels stay off: temperature must still run
        wr(`IFT_OFS_TEMP_CAL_MUL, 8'h03);
        wr(`IFT_OFS_TEMP_CAL_DIV, 8'h01);
        wr(`IFT_OFS_TEMP_CAL_OFS, 8'h05);
        wr(`IFT_OFS_TEMP_SETTINGS, 8'h80);
        temp_run(16'h1000, t_exp(8'h03, 8'h01, 8'h05, 16'h1000), 8'h00, 0);
        temp_run(16'h0800, t_exp(8'h03, 8'h01, 8'h05, 16'h0800), 8'h80, 1);
        temp_run(16'h0800, 16'h0205, 8'h00, 1);
        temp_run(16'h0000, 16'h0205, 8'h00, 1);
        rd(`IFT_OFS_TEMP_OUT_LO, 8'h05);
        `TB_CHK(old_rdata, 8'h00)
        sense.load(8'hff, 8'h00, 8'h03, 4'h9);
        rd(`IFT_OFS_TEMP_CAL_MUL, 8'hff);
        `TB_CHK(old_rdata, 8'hf0)
        rd(`IFT_OFS_TEMP_CAL_DIV, 8'h00);
        `TB_CHK(old_rdata, 8'h03)
        rd(`IFT_OFS_TEMP_CAL_OFS, 8'h03);
        `TB_CHK(old_rdata, 8'h00)
        `TB_CHK(temp_gain_select, 8'h09)
        @(posedge ref_clk);
        magnetic_ch_en <= 1'b1;
        temp_run(16'h0001, 16'hffff, 8'h80, 2);
        rd(`IFT_OFS_TEMP_OUT_HI, 8'hff);
        `TB_CHK(old_rdata, 8'hff)
        final_report();
    end
endmodule
